// [fpec_ctrl.sv]
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Operation
// RQ1 - frequency high and low bytes form one 16-bit kHz value timing every operation
// RQ2 - software loads the frequency value with the clock rate in hertz over 1000
// RQ3 - software sets both frequency bytes before asking for program or erase
// RQ4 - software never programs or erases below 32768 Hz or above 20 MHz
// RQ5 - page erase clears exactly one 512-byte page to ff
// RQ6 - page select names the target; erase runs only outside protected sectors (the code lets the debugger erase protected sectors too)
// RQ7 - unlocked with page set, command 95 starts the page erase
// RQ8 - processor is stalled during erase, clock and peripherals keep running
// RQ9 - debugger polls status until page erase completes
// RQ10 - controller relocks itself when a page or mass erase completes
// RQ11 - mass erase only through the debugger, sets all flash to ff
// RQ12 - unlocked with mass erase enabled, command 63 starts the mass erase
// RQ13 - debugger polls status to learn mass erase completion
// RQ14 - read-protect option stops user code reaching the debugger
// RQ15 - read and write protect options pick one of three levels
// RQ16 - options, locking, redundant page select and sector protect guard writes
// RQ17 - information area sits at fe00 to ffff, only partly live
// RQ18 - bypass routes flash array controls straight from the pins
// RQ19 - unlock needs 73 then 8c as consecutive command writes
// RQ20 - erase command acts only as third write right after unlock pair
// RQ21 - command 5e opens access to the sector protect register
// RQ22 - stray or unknown command writes relock without starting anything
// RQ23 - erase time counts clocks scaled by the frequency value; busy until done
module fpec_ctrl #(
   parameter int              PAGE_W        = 4,
   parameter int              SECT_W        = 3,
   parameter logic [15:0]     PAGE_ERASE_MS = fpec_pkg::FPEC_PAGE_ERASE_MS,
   parameter logic [15:0]     MASS_ERASE_MS = fpec_pkg::FPEC_MASS_ERASE_MS
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // option bits and debugger
   input  wire logic              opt_read_protect,
   input  wire logic              opt_write_protect,
   input  wire logic              dbg_mode,
   output logic                   dbg_read_block,
   output logic [1:0]             prot_level,
   // processor side
   input  wire logic [15:0]       mem_addr,
   output logic                   info_sel,
   output logic                   cpu_stall,
   // bypass pins
   input  wire logic              byp_erase,
   input  wire logic              byp_prog,
   input  wire logic [PAGE_W-1:0] byp_page,
   // flash array
   output logic                   fl_page_erase,
   output logic                   fl_mass_erase,
   output logic                   fl_prog,
   output logic [PAGE_W-1:0]      fl_page
);
   import fpec_pkg::*;

   // ==========================================
   // state
   // ==========================================
   fpec_state_t         st_ff, nxt_st;
   logic [7:0]          frqh_ff, frql_ff;
   logic [7:0]          sprot_ff;
   logic [PAGE_W-1:0]   page_ff;
   logic                page_vld_ff;
   logic                spr_acc_ff;
   logic                mass_en_ff;
   logic                byp_ff;
   logic [15:0]         pre_cnt_ff;
   logic [15:0]         ms_cnt_ff;
   logic [31:0]         prdata_ff;
   logic                pready_ff, pslverr_ff;
   logic                stall_ff, rd_block_ff, info_ff;
   logic [1:0]          lvl_ff;
   logic                fl_pe_ff, fl_me_ff, fl_pg_ff;
   logic [PAGE_W-1:0]   fl_page_ff;

   // sector that holds a page
   function automatic logic [SECT_W-1:0] sector_of(input logic [PAGE_W-1:0] pg);
      sector_of = pg[PAGE_W-1 -: SECT_W];
   endfunction

   // ==========================================
   // apb decode
   // ==========================================
   wire         wr_en    = psel && penable && pwrite && pready_ff;
   wire         rd_setup = psel && !penable;
   wire [7:0]   wdat     = pwdata[7:0];
   wire         hit_cmd  = paddr == FPEC_CMD_OFS;
   wire         hit_stat = paddr == FPEC_STAT_OFS;
   wire         hit_page = paddr == FPEC_PAGE_OFS;
   wire         hit_spr  = paddr == FPEC_SPROT_OFS;
   wire         hit_frqh = paddr == FPEC_FRQH_OFS;
   wire         hit_frql = paddr == FPEC_FRQL_OFS;
   wire         hit_opt  = paddr == FPEC_OPT_OFS;
   wire         mapped   = hit_cmd | hit_stat | hit_page | hit_spr | hit_frqh | hit_frql | hit_opt;
   wire         busy     = (st_ff == st_page_erase) || (st_ff == st_mass_erase);
   // commands are ignored while an erase runs; the processor is stalled anyway
   wire         cmd_wr   = wr_en && hit_cmd && !busy;

   // ==========================================
   // protection and start checks
   // ==========================================
   wire [15:0]  frq_khz  = {frqh_ff, frql_ff}; // see RQ1
   // a zero frequency still ticks once per cycle rather than hanging
   wire [15:0]  frq_m1   = (frq_khz == 16'h0000) ? 16'h0000 : frq_khz - 16'h0001;
   wire         sect_hit = sprot_ff[sector_of(page_ff)];
   // debugger ignores write protect and sector protect
   wire         page_ok  = page_vld_ff && (dbg_mode || (!sect_hit && !opt_write_protect)); // see RQ6 see RQ16
   wire         mass_ok  = dbg_mode && mass_en_ff; // see RQ11
   wire         go_page  = cmd_wr && st_ff == st_unlocked && wdat == FPEC_CMD_PAGE && page_ok; // see RQ7 see RQ20
   wire         go_mass  = cmd_wr && st_ff == st_unlocked && wdat == FPEC_CMD_MASS && mass_ok; // see RQ12 see RQ20
   wire [1:0]   nxt_lvl  = opt_read_protect ? FPEC_LVL_FULL :
                           opt_write_protect ? FPEC_LVL_WRITE : FPEC_LVL_NONE; // see RQ15

   // ==========================================
   // erase timer
   // ==========================================
   wire         ms_tick  = pre_cnt_ff == frq_m1; // see RQ23
   wire [15:0]  len_ms   = (st_ff == st_mass_erase) ? MASS_ERASE_MS : PAGE_ERASE_MS;
   wire         erase_end = busy && ms_tick && (ms_cnt_ff == len_ms - 16'h0001);

   // ==========================================
   // sequencer next state
   // ==========================================
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         st_locked: begin
            if (cmd_wr && wdat == FPEC_CMD_UNL1) begin
               nxt_st = st_unl1; // see RQ19
            end
         end
         st_unl1: begin
            if (cmd_wr) begin
               nxt_st = (wdat == FPEC_CMD_UNL2) ? st_unlocked : st_locked; // see RQ19 see RQ22
            end
         end
         st_unlocked: begin
            if (go_page) begin
               nxt_st = st_page_erase;
            end else if (go_mass) begin
               nxt_st = st_mass_erase;
            end else if (cmd_wr) begin
               nxt_st = st_locked; // see RQ22
            end
         end
         st_page_erase, st_mass_erase: begin
            if (erase_end) begin
               nxt_st = st_locked; // see RQ10
            end
         end
         default: nxt_st = st_locked;
      endcase
   end

   // ==========================================
   // read mux
   // ==========================================
   wire [31:0] stat_w = {27'h0, lvl_ff, spr_acc_ff, st_ff == st_unlocked, busy}; // see RQ9 see RQ13
   wire [31:0] nxt_prdata =
      hit_stat ? stat_w :
      hit_page ? {{(32-PAGE_W){1'b0}}, page_ff} :
      hit_spr  ? {24'h0, sprot_ff} :
      hit_frqh ? {24'h0, frqh_ff} :
      hit_frql ? {24'h0, frql_ff} :
      hit_opt  ? {30'h0, byp_ff, mass_en_ff} : 32'h0;

   // ==========================================
   // bus slave: no wait states, answer from flops
   // ==========================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         pready_ff  <= rd_setup;
         pslverr_ff <= rd_setup && !mapped;
         prdata_ff  <= rd_setup ? nxt_prdata : 32'h0;
      end
   end

   // ==========================================
   // software registers
   // ==========================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frqh_ff <= FPEC_FRQ_RST;
         frql_ff <= FPEC_FRQ_RST;
         byp_ff  <= 1'b0;
      end else begin
         if (wr_en && hit_frqh) begin
            frqh_ff <= wdat;
         end
         if (wr_en && hit_frql) begin
            frql_ff <= wdat;
         end
         if (wr_en && hit_opt) begin
            byp_ff <= wdat[FPEC_OPT_BYP_BIT];
         end
      end
   end

   // ==========================================
   // page select, sector protect, mass enable
   // ==========================================
   // page valid is a second, redundant arming step that each page erase consumes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_ff     <= '0;
         page_vld_ff <= 1'b0;
         sprot_ff    <= FPEC_SPROT_RST;
         spr_acc_ff  <= 1'b0;
         mass_en_ff  <= 1'b0;
      end else begin
         if (wr_en && hit_page && !busy) begin
            page_ff     <= wdat[PAGE_W-1:0];
            page_vld_ff <= 1'b1; // see RQ16
         end else if (go_page) begin
            page_vld_ff <= 1'b0;
         end
         // sector protect bits only set; a write opens one access
         if (wr_en && hit_spr && spr_acc_ff) begin
            sprot_ff   <= sprot_ff | wdat;
            spr_acc_ff <= 1'b0;
         end else if (cmd_wr) begin
            spr_acc_ff <= (st_ff == st_locked) && wdat == FPEC_CMD_SPREN; // see RQ21
         end
         if (wr_en && hit_opt && dbg_mode) begin
            mass_en_ff <= wdat[FPEC_OPT_MASS_BIT]; // see RQ11
         end else if (erase_end) begin
            mass_en_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // sequencer and erase timer
   // ==========================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff      <= st_locked;
         pre_cnt_ff <= 16'h0;
         ms_cnt_ff  <= 16'h0;
      end else begin
         st_ff <= nxt_st;
         if (!busy || ms_tick) begin
            pre_cnt_ff <= 16'h0;
         end else begin
            pre_cnt_ff <= pre_cnt_ff + 16'h0001; // see RQ23
         end
         if (!busy) begin
            ms_cnt_ff <= 16'h0;
         end else if (ms_tick) begin
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
         end
      end
   end

   // ==========================================
   // outputs to cpu, debugger and flash array
   // ==========================================
   // bypass hands the array straight to the pins, one flop of delay
   wire info_hit = mem_addr >= FPEC_INFO_BASE && mem_addr <= FPEC_INFO_LIVE; // see RQ17
   wire nxt_pe   = byp_ff ? byp_erase : (nxt_st == st_page_erase); // see RQ5 see RQ18
   wire nxt_me   = !byp_ff && (nxt_st == st_mass_erase);
   wire [PAGE_W-1:0] nxt_fpage = byp_ff ? byp_page : page_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_ff    <= 1'b0;
         rd_block_ff <= 1'b0;
         lvl_ff      <= FPEC_LVL_NONE;
         info_ff     <= 1'b0;
         fl_pe_ff    <= 1'b0;
         fl_me_ff    <= 1'b0;
         fl_pg_ff    <= 1'b0;
         fl_page_ff  <= '0;
      end else begin
         stall_ff    <= nxt_st == st_page_erase || nxt_st == st_mass_erase; // see RQ8
         rd_block_ff <= opt_read_protect; // see RQ14
         lvl_ff      <= nxt_lvl;
         info_ff     <= info_hit;
         fl_pe_ff    <= nxt_pe;
         fl_me_ff    <= nxt_me; // see RQ11
         fl_pg_ff    <= byp_ff && byp_prog; // see RQ18
         fl_page_ff  <= nxt_fpage;
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign cpu_stall      = stall_ff;
   assign dbg_read_block = rd_block_ff;
   assign prot_level     = lvl_ff;
   assign info_sel       = info_ff;
   assign fl_page_erase  = fl_pe_ff;
   assign fl_mass_erase  = fl_me_ff;
   assign fl_prog        = fl_pg_ff;
   assign fl_page        = fl_page_ff;

   // ==========================================
   // checks
   // ==========================================
   // bus writes are never on adjacent cycles, so the pair is judged from the half-unlocked state
   a_unlock_pair: assert property (@(posedge pclk) disable iff (!presetn) // see RQ19
      (cmd_wr && st_ff == st_unl1 && wdat == FPEC_CMD_UNL2) |=> st_ff == st_unlocked)
      else $error("unlock pair did not unlock");

   a_stray_relock: assert property (@(posedge pclk) disable iff (!presetn) // see RQ22
      (cmd_wr && st_ff == st_unl1 && wdat != FPEC_CMD_UNL2) |=> st_ff == st_locked && !busy)
      else $error("stray command did not relock");

   a_page_start: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
      go_page && !byp_ff |=> st_ff == st_page_erase && fl_page_erase && fl_page == $past(page_ff))
      else $error("page erase did not start");

   a_sect_guard: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
      (cmd_wr && st_ff == st_unlocked && sect_hit && !dbg_mode) |=> st_ff != st_page_erase)
      else $error("protected sector erased");

   a_stall_erase: assert property (@(posedge pclk) disable iff (!presetn) // see RQ8
      busy |-> cpu_stall)
      else $error("cpu not stalled during erase");

   a_end_relock: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
      erase_end |=> st_ff == st_locked ##1 !cpu_stall)
      else $error("no relock after erase");

   a_mass_debug: assert property (@(posedge pclk) disable iff (!presetn) // see RQ11
      $rose(st_ff == st_mass_erase) |-> $past(dbg_mode) && $past(mass_en_ff))
      else $error("mass erase without debugger");

   a_read_block: assert property (@(posedge pclk) disable iff (!presetn) // see RQ14
      opt_read_protect ##1 opt_read_protect |-> dbg_read_block && prot_level == FPEC_LVL_FULL)
      else $error("debugger read not blocked");

   a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn) // see RQ23
      (busy && ms_tick && frq_khz > 16'd2 && $stable(frq_khz)) |=> !ms_tick ##1 !ms_tick)
      else $error("erase tick spacing wrong");
endmodule // fpec_ctrl

// [fpec_ctrl_tb.sv]
`timescale 1ns/100ps
// =============================================
// flash program/erase controller testbench
// =============================================
module fpec_ctrl_tb;
   import fpec_pkg::*;
   // short erase times keep the run brief
   localparam logic [15:0] PMS = 16'd2;
   localparam logic [15:0] MMS = 16'd3;
   localparam logic [15:0] FQ  = 16'h0005;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        opt_read_protect, opt_write_protect, dbg_mode, dbg_read_block;
   logic [1:0]  prot_level;
   logic [15:0] mem_addr, blank;
   logic        info_sel, cpu_stall, byp_erase, byp_prog, er;
   logic [3:0]  byp_page, fl_page;
   logic        fl_page_erase, fl_mass_erase, fl_prog;
   int          errors, samples_checked, cycles;

   fpec_ctrl #(.PAGE_ERASE_MS(PMS), .MASS_ERASE_MS(MMS)) fpec_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .opt_read_protect(opt_read_protect), .opt_write_protect(opt_write_protect),
      .dbg_mode(dbg_mode), .dbg_read_block(dbg_read_block), .prot_level(prot_level),
      .mem_addr(mem_addr), .info_sel(info_sel), .cpu_stall(cpu_stall), .byp_erase(byp_erase),
      .byp_prog(byp_prog), .byp_page(byp_page), .fl_page_erase(fl_page_erase),
      .fl_mass_erase(fl_mass_erase), .fl_prog(fl_prog), .fl_page(fl_page));
   fpec_flash_model #(.PAGE_W(4)) fpec_flash_model_i (
      .pclk(pclk), .presetn(presetn), .fl_page_erase(fl_page_erase),
      .fl_mass_erase(fl_mass_erase), .fl_prog(fl_prog), .fl_page(fl_page), .blank_ff(blank));

   // =============================================
   // clock and hang guard
   // =============================================
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ceiling well above the few hundred cycles the tests need
   initial begin
      cycles = 0;
      forever begin
         @(posedge pclk);
         cycles++;
         if (cycles == 20000) begin
            errors++;
            $display("ERROR %0t timeout", $time);
            stop_test();
         end
      end
   end

   // =============================================
   // shared tasks
   // =============================================
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // pready sampled at the rising edge that ends the access; only the hang guard ends the wait
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      chk(n, 1, "pready wait");
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   // counts cycles of stall; zero expected when the command must be refused
   task measure(input logic [7:0] cmd, input logic [3:0] pg, input int exp_n);
      int n;
      n = 0;
      for (int i = 0; i < 4 && cpu_stall !== 1'b1; i++) @(negedge pclk);
      if (exp_n != 0 && cmd == FPEC_CMD_PAGE) chk({fl_page_erase, fl_page}, {1'b1, pg}, "page strobe");
      if (exp_n != 0 && cmd == FPEC_CMD_MASS) chk(fl_mass_erase, 1'b1, "mass strobe");
      while (cpu_stall === 1'b1 && n < 3000) begin
         n++;
         @(negedge pclk);
      end
      chk(n, exp_n, "erase cycles");
   endtask
   task erase_run(input logic [7:0] cmd, input logic [3:0] pg, input int exp_n);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL1);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL2);
      wr(FPEC_CMD_OFS, cmd);
      measure(cmd, pg, exp_n);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // =============================================
   // scenarios
   // =============================================
   task t_regs;
      rdchk(FPEC_STAT_OFS, 32'h0, "status at reset");
      rdchk(FPEC_FRQH_OFS, {24'h0, FPEC_FRQ_RST}, "freq high reset");
      rdchk(FPEC_SPROT_OFS, {24'h0, FPEC_SPROT_RST}, "sector reset");
      apb(1'b0, 8'h1c, 32'h0);
      chk(er, 1'b1, "unmapped error");
      wr(FPEC_FRQH_OFS, 8'h12);
      wr(FPEC_FRQL_OFS, 8'h34);
      rdchk(FPEC_FRQL_OFS, 32'h34, "freq low");
      wr(FPEC_FRQH_OFS, FQ[15:8]);
      wr(FPEC_FRQL_OFS, FQ[7:0]);
      $display("test regs done");
   endtask
   task t_opts_info;
      logic [15:0] ia [4];
      ia = '{16'hfdff, 16'hfe00, 16'hfe7f, 16'hfe80};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         opt_read_protect <= i[1]; opt_write_protect <= i[0]; mem_addr <= ia[i];
         repeat (3) @(negedge pclk);
         chk(dbg_read_block, i[1], "read block");
         chk(prot_level, i[1] ? FPEC_LVL_FULL : (i[0] ? FPEC_LVL_WRITE : FPEC_LVL_NONE), "level");
         chk(info_sel, i == 1 || i == 2, "info select");
      end
      @(posedge pclk);
      opt_read_protect <= 1'b0; opt_write_protect <= 1'b0;
      $display("test options done");
   endtask
   task t_page;
      wr(FPEC_PAGE_OFS, 8'h03);
      erase_run(FPEC_CMD_PAGE, 4'h3, PMS * FQ);
      chk(blank, 16'h0008, "one page blank");
      rdchk(FPEC_STAT_OFS, 32'h0, "idle and relocked");
      erase_run(FPEC_CMD_PAGE, 4'h3, 0);
      wr(FPEC_PAGE_OFS, 8'h05);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL1);
      wr(FPEC_CMD_OFS, FPEC_CMD_PAGE);
      measure(FPEC_CMD_PAGE, 4'h5, 0);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL2);
      wr(FPEC_CMD_OFS, FPEC_CMD_PAGE);
      measure(FPEC_CMD_PAGE, 4'h5, 0);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL1);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL2);
      rdchk(FPEC_STAT_OFS, 32'h2, "unlocked");
      wr(FPEC_CMD_OFS, 8'h11);
      rdchk(FPEC_STAT_OFS, 32'h0, "relocked");
      wr(FPEC_CMD_OFS, FPEC_CMD_PAGE);
      measure(FPEC_CMD_PAGE, 4'h5, 0);
      $display("test page erase done");
   endtask
   task t_sector;
      wr(FPEC_SPROT_OFS, 8'h10);
      rdchk(FPEC_SPROT_OFS, 32'h0, "sector closed");
      wr(FPEC_CMD_OFS, FPEC_CMD_SPREN);
      wr(FPEC_SPROT_OFS, 8'h10);
      rdchk(FPEC_SPROT_OFS, 32'h10, "sector open");
      wr(FPEC_PAGE_OFS, 8'h08);
      erase_run(FPEC_CMD_PAGE, 4'h8, 0);
      opt_write_protect <= 1'b1;
      wr(FPEC_PAGE_OFS, 8'h05);
      erase_run(FPEC_CMD_PAGE, 4'h5, 0);
      opt_write_protect <= 1'b0;
      dbg_mode <= 1'b1;
      wr(FPEC_PAGE_OFS, 8'h08);
      erase_run(FPEC_CMD_PAGE, 4'h8, PMS * FQ);
      chk(blank, 16'h0108, "debugger page");
      dbg_mode <= 1'b0;
      $display("test sector done");
   endtask
   task t_mass;
      wr(FPEC_OPT_OFS, 8'h01);
      erase_run(FPEC_CMD_MASS, 4'h0, 0);
      dbg_mode <= 1'b1;
      wr(FPEC_OPT_OFS, 8'h01);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL1);
      wr(FPEC_CMD_OFS, FPEC_CMD_UNL2);
      wr(FPEC_CMD_OFS, FPEC_CMD_MASS);
      apb(1'b0, FPEC_STAT_OFS, 32'h0);
      chk({fl_mass_erase, cpu_stall, rd[0]}, 3'b111, "mass busy");
      for (int k = 0; k < 100 && rd[0] !== 1'b0; k++) apb(1'b0, FPEC_STAT_OFS, 32'h0);
      chk(rd[1:0], 2'b00, "mass done relocked");
      chk(blank, 16'hffff, "all blank");
      dbg_mode <= 1'b0;
      $display("test mass erase done");
   endtask
   task t_bypass;
      wr(FPEC_OPT_OFS, 8'h02);
      byp_page <= 4'h9; byp_erase <= 1'b1;
      repeat (3) @(negedge pclk);
      chk({fl_page_erase, fl_mass_erase, fl_page}, {2'b10, 4'h9}, "bypass erase");
      @(posedge pclk);
      byp_erase <= 1'b0; byp_prog <= 1'b1;
      repeat (3) @(negedge pclk);
      chk({fl_page_erase, fl_prog, blank}, {2'b01, 16'hfdff}, "bypass prog");
      @(posedge pclk);
      byp_prog <= 1'b0;
      wr(FPEC_OPT_OFS, 8'h00);
      $display("test bypass done");
   endtask

   // =============================================
   // main sequence
   // =============================================
   initial begin
      errors = 0; samples_checked = 0; presetn = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      opt_read_protect = 1'b0; opt_write_protect = 1'b0; dbg_mode = 1'b0; mem_addr = 16'h0;
      byp_erase = 1'b0; byp_prog = 1'b0; byp_page = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_opts_info();
      t_page();
      t_sector();
      t_mass();
      t_bypass();
      stop_test();
   end
endmodule // fpec_ctrl_tb

// [fpec_flash_model.sv]
`timescale 1ns/100ps
// =============================================
// flash array model: one blank flag per page
// =============================================
module fpec_flash_model #(
   parameter int PAGE_W = 4
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // array controls
   input  wire logic              fl_page_erase,
   input  wire logic              fl_mass_erase,
   input  wire logic              fl_prog,
   input  wire logic [PAGE_W-1:0] fl_page,
   // page reads all ff
   output logic [2**PAGE_W-1:0]   blank_ff
);
   // flags only, not bytes: a page is blank or not, partial erase is not modelled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_ff <= '0;
      end else if (fl_mass_erase) begin
         blank_ff <= '1;
      end else if (fl_page_erase) begin
         blank_ff[fl_page] <= 1'b1;
      end else if (fl_prog) begin
         blank_ff[fl_page] <= 1'b0;
      end
   end
endmodule // fpec_flash_model

// [fpec_pkg.sv]
// =============================================
// flash program/erase controller constants
// =============================================
package fpec_pkg;
   // apb register byte offsets
   localparam logic [7:0] FPEC_CMD_OFS   = 8'h00;
   localparam logic [7:0] FPEC_STAT_OFS  = 8'h04;
   localparam logic [7:0] FPEC_PAGE_OFS  = 8'h08;
   localparam logic [7:0] FPEC_SPROT_OFS = 8'h0c;
   localparam logic [7:0] FPEC_FRQH_OFS  = 8'h10;
   localparam logic [7:0] FPEC_FRQL_OFS  = 8'h14;
   localparam logic [7:0] FPEC_OPT_OFS   = 8'h18;
   // command codes
   localparam logic [7:0] FPEC_CMD_UNL1  = 8'h73;
   localparam logic [7:0] FPEC_CMD_UNL2  = 8'h8c;
   localparam logic [7:0] FPEC_CMD_PAGE  = 8'h95;
   localparam logic [7:0] FPEC_CMD_MASS  = 8'h63;
   localparam logic [7:0] FPEC_CMD_SPREN = 8'h5e;
   // option register fields
   localparam int FPEC_OPT_MASS_BIT = 0;
   localparam int FPEC_OPT_BYP_BIT  = 1;
   // status register fields
   localparam int FPEC_ST_BUSY_BIT  = 0;
   localparam int FPEC_ST_UNL_BIT   = 1;
   localparam int FPEC_ST_SPR_BIT   = 2;
   localparam int FPEC_ST_LVL_LSB   = 3;
   // reset values
   localparam logic [7:0] FPEC_FRQ_RST   = 8'h00;
   localparam logic [7:0] FPEC_SPROT_RST = 8'h00;
   // erase durations in milliseconds
   localparam logic [15:0] FPEC_PAGE_ERASE_MS = 16'd10;
   localparam logic [15:0] FPEC_MASS_ERASE_MS = 16'd200;
   // information area window
   localparam logic [15:0] FPEC_INFO_BASE = 16'hfe00;
   localparam logic [15:0] FPEC_INFO_LIVE = 16'hfe7f;
   // protection levels
   localparam logic [1:0] FPEC_LVL_NONE  = 2'd0;
   localparam logic [1:0] FPEC_LVL_WRITE = 2'd1;
   localparam logic [1:0] FPEC_LVL_FULL  = 2'd2;
   // sequencer states
   typedef enum logic [2:0] {
      st_locked, st_unl1, st_unlocked, st_page_erase, st_mass_erase
   } fpec_state_t;
endpackage
